/* mac_dma_call_ctrl.v */
// Hardware function call front end for the MAC DMA and buffer RAM DMA:
// argument checks, result word, error routing, receive descriptor hand-off.
// Assumes a classic Wishbone master and DMA engines that answer every
// started call with call_done_i, flagging a prohibited access on call_fault_i.
//
// What this block does
// - Descriptor bits 27:16 hold received word count
// - Start address: 00001b on top, zero low
// - Descriptor 15:7, 6:0 map to 26:18, 17:11
// - Invalid DMA call argument returns invalid-call code
// - MAC DMA runtime error raises interrupt, no exception
// - Violation bit: unacquired, bad count, misaligned descriptor
// - Timeout bit: end descriptor or release failure
// - Copy/replace prohibited access returns exception code
// - Buffer DMA launch prohibited access raises interrupt
// - Copy source first argument, destination second
// - Pulse transmit error interrupt on any transmit MAC DMA error
// - Pulse buffer area interrupt on unacquired access
//
// Added by the designer: the register offsets and the Wishbone register port.
`include "mac_dma_call_defs.vh"
`default_nettype none

module mac_dma_call_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Call issue to the DMA engines
  output reg call_start_o,
  output reg [3:0] call_code_o,
  output reg [31:0] src_addr_o,
  output reg [31:0] dst_addr_o,
  input wire call_done_i,
  input wire call_fault_i,
  // Receive MAC DMA buffer hand-off
  input wire rx_done_i,
  input wire [11:0] rx_word_count_i,
  input wire [31:0] rx_buf_addr_i,
  // Transmit MAC DMA error causes
  input wire tx_unacquired_i,
  input wire tx_bad_count_i,
  input wire tx_desc_valid_i,
  input wire [31:0] tx_desc_addr_i,
  input wire tx_auto_release_fail_i,
  // Unacquired buffer RAM access by CPU or MAC DMA
  input wire bram_unacquired_i,
  // Interrupts
  output reg tx_dma_error_irq_o,
  output reg buffer_area_error_irq_o,
  output wire irq_o
);

  // ========================================================================
  // Call state machine states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CHECK = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [3:0] call_code;
  reg [31:0] first_arg;
  reg [31:0] second_arg;
  reg [31:0] result_word;
  reg [31:0] rx_desc;
  reg [`IRQ_W-1:0] irq_status;
  reg [`IRQ_W-1:0] irq_enable;
  reg ack;
  reg args_bad;
  reg [`IRQ_W-1:0] irq_set;

  wire wb_req;
  wire wb_wr;
  wire wb_wr_full;
  wire call_write;
  wire query_now;
  wire tx_err_pulse;
  wire [1:0] tx_cause;
  wire [31:0] rx_desc_next;
  wire [31:0] rx_start_addr;
  wire mac_call;
  wire direct_call;
  wire launch_call;

  // ========================================================================
  // Wishbone: one wait state, ack drops the cycle after it rises
  assign wb_req = wb_cyc_i && wb_stb_i && !ack;
  assign wb_wr = wb_req && wb_we_i;
  // Partial writes would tear an address; only full words are stored
  assign wb_wr_full = wb_wr && (wb_sel_i == 4'hF);
  assign wb_ack_o = ack;
  // A call written while another runs is dropped; software polls busy
  assign call_write = wb_wr_full && (wb_adr_i == `OFS_CALL_CODE) && (state == ST_IDLE);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= wb_req;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      first_arg <= 32'h0000_0000;
      second_arg <= 32'h0000_0000;
      irq_enable <= {`IRQ_W{1'b0}};
    end else if (wb_wr_full && (state == ST_IDLE)) begin
      case (wb_adr_i)
        `OFS_FIRST_ARG: begin
          first_arg <= wb_dat_i;
        end
        `OFS_SECOND_ARG: begin
          second_arg <= wb_dat_i;
        end
        `OFS_IRQ_ENABLE: begin
          irq_enable <= wb_dat_i[`IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end else if (wb_wr_full && (wb_adr_i == `OFS_IRQ_ENABLE)) begin
      irq_enable <= wb_dat_i[`IRQ_W-1:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `OFS_CALL_CODE: wb_dat_o <= {28'h000_0000, call_code};
        `OFS_FIRST_ARG: wb_dat_o <= first_arg;
        `OFS_SECOND_ARG: wb_dat_o <= second_arg;
        `OFS_RESULT_WORD: wb_dat_o <= result_word;
        `OFS_RX_DESC: wb_dat_o <= rx_desc;
        `OFS_RX_START_ADDR: wb_dat_o <= rx_start_addr;
        `OFS_IRQ_STATUS: wb_dat_o <= {28'h000_0000, irq_status};
        `OFS_IRQ_ENABLE: wb_dat_o <= {28'h000_0000, irq_enable};
        `OFS_CALL_STATUS: wb_dat_o <= {31'h0000_0000, state != ST_IDLE};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Receive buffer descriptor
  rx_descriptor_pack u_rx_pack (
    .word_count_i(rx_word_count_i),
    .buf_addr_i(rx_buf_addr_i),
    .desc_i(rx_desc),
    .desc_o(rx_desc_next),
    .start_addr_o(rx_start_addr)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_desc <= 32'h0000_0000;
    end else if (rx_done_i) begin
      rx_desc <= rx_desc_next;
    end
  end

  // ========================================================================
  // Transmit error causes
  assign query_now = (state == ST_CHECK) && (call_code == `CALL_TX_ERR_QUERY);

  tx_error_tracker u_tx_err (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .unacquired_i(tx_unacquired_i),
    .bad_count_i(tx_bad_count_i),
    .desc_valid_i(tx_desc_valid_i),
    .desc_addr_i(tx_desc_addr_i),
    .auto_release_fail_i(tx_auto_release_fail_i),
    .query_i(query_now),
    .cause_o(tx_cause),
    .error_pulse_o(tx_err_pulse)
  );

  // ========================================================================
  // Call sequencing
  assign mac_call = (call_code == `CALL_RX_DMA) || (call_code == `CALL_TX_DMA);
  assign direct_call = (call_code == `CALL_DIRECT_COPY) ||
                       (call_code == `CALL_DIRECT_REPLACE);
  assign launch_call = (call_code == `CALL_BRAM_LAUNCH) ||
                       (call_code == `CALL_BRAM_LAUNCH_DESC);

  // Arguments are word addresses; copy and replace need two of them
  always @* begin
    args_bad = 1'b0;
    case (call_code)
      `CALL_RX_DMA, `CALL_TX_DMA, `CALL_BRAM_LAUNCH, `CALL_BRAM_LAUNCH_DESC,
      `CALL_BUF_RELEASE: begin
        args_bad = (first_arg[1:0] != 2'h0) || (first_arg == 32'h0000_0000);
      end
      `CALL_DIRECT_COPY, `CALL_DIRECT_REPLACE: begin
        args_bad = (first_arg[1:0] != 2'h0) || (second_arg[1:0] != 2'h0) ||
                   (first_arg == 32'h0000_0000) || (second_arg == 32'h0000_0000);
      end
      `CALL_TX_ERR_QUERY: begin
        args_bad = 1'b0;
      end
      default: begin
        args_bad = 1'b1;
      end
    endcase
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (call_write) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (args_bad || (call_code == `CALL_TX_ERR_QUERY)) begin
          next_state = ST_DONE;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (call_done_i) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      call_code <= 4'h0;
      result_word <= `RESULT_OK;
      call_start_o <= 1'b0;
      call_code_o <= 4'h0;
      src_addr_o <= 32'h0000_0000;
      dst_addr_o <= 32'h0000_0000;
    end else begin
      state <= next_state;
      call_start_o <= 1'b0;
      if (call_write) begin
        call_code <= wb_dat_i[3:0];
      end
      if (state == ST_CHECK) begin
        if (args_bad) begin
          result_word <= `RESULT_INVALID_CALL;
        end else if (call_code == `CALL_TX_ERR_QUERY) begin
          result_word <= {30'h0000_0000, tx_cause};
        end else begin
          result_word <= `RESULT_OK;
          call_start_o <= 1'b1;
          call_code_o <= call_code;
          src_addr_o <= first_arg;
          dst_addr_o <= second_arg;
        end
      end
      if ((state == ST_RUN) && call_done_i && call_fault_i && direct_call) begin
        result_word <= `RESULT_EXCEPTION;
      end
    end
  end

  // ========================================================================
  // Interrupt pulses and sticky status
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_dma_error_irq_o <= 1'b0;
      buffer_area_error_irq_o <= 1'b0;
    end else begin
      tx_dma_error_irq_o <= tx_err_pulse ||
        ((state == ST_RUN) && call_done_i && call_fault_i &&
         (call_code == `CALL_TX_DMA));
      buffer_area_error_irq_o <= bram_unacquired_i ||
        ((state == ST_RUN) && call_done_i && call_fault_i &&
         (launch_call || (call_code == `CALL_RX_DMA)));
    end
  end

  always @* begin
    irq_set = {`IRQ_W{1'b0}};
    irq_set[`IRQ_CALL_DONE] = (state == ST_DONE);
    irq_set[`IRQ_TX_ERROR] = tx_dma_error_irq_o;
    irq_set[`IRQ_BUF_AREA] = buffer_area_error_irq_o;
    irq_set[`IRQ_RX_READY] = rx_done_i;
  end

  // A set in the clearing cycle survives the clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= {`IRQ_W{1'b0}};
    end else if (wb_wr && (wb_adr_i == `OFS_IRQ_CLEAR) && wb_sel_i[0]) begin
      irq_status <= (irq_status & ~wb_dat_i[`IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  assign irq_o = |(irq_status & irq_enable);

endmodule // mac_dma_call_ctrl

`default_nettype wire

/* mac_dma_call_defs.vh */
// Constants for the hardware function call error and buffer hand-off logic.
// Assumes inclusion by bare name from the design files of this block.
`ifndef MAC_DMA_CALL_DEFS_VH
`define MAC_DMA_CALL_DEFS_VH

// ==========================================================================
// Register byte offsets (Wishbone, one aligned word each)
`define OFS_CALL_CODE 8'h00
`define OFS_FIRST_ARG 8'h04
`define OFS_SECOND_ARG 8'h08
`define OFS_RESULT_WORD 8'h0C
`define OFS_RX_DESC 8'h10
`define OFS_RX_START_ADDR 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_CLEAR 8'h1C
`define OFS_IRQ_ENABLE 8'h20
`define OFS_CALL_STATUS 8'h24

// ==========================================================================
// Call codes, written to the call code register
`define CALL_RX_DMA 4'h1
`define CALL_TX_DMA 4'h2
`define CALL_BRAM_LAUNCH 4'h3
`define CALL_BRAM_LAUNCH_DESC 4'h4
`define CALL_DIRECT_COPY 4'h5
`define CALL_DIRECT_REPLACE 4'h6
`define CALL_TX_ERR_QUERY 4'h7
`define CALL_BUF_RELEASE 4'h8

// ==========================================================================
// Result words
`define RESULT_OK 32'h0000_0000
`define RESULT_INVALID_CALL 32'hFFFF_FFF1
`define RESULT_EXCEPTION 32'hFFFF_FFF2

// ==========================================================================
// Received buffer descriptor layout and start address pattern
`define DESC_COUNT_HI 27
`define DESC_COUNT_LO 16
`define DESC_ADDR_HI 15
`define DESC_ADDR_LO 0
`define ADDR_PATTERN_HI 31
`define ADDR_PATTERN_LO 27
`define ADDR_PATTERN 5'h01
`define ADDR_BUF_HI 26
`define ADDR_BUF_LO 11
`define ADDR_ZERO_W 11
`define DESC_PAD_W 4

// ==========================================================================
// Transmit error query result and end-of-chain descriptor value
`define TXERR_VIOLATION_BIT 0
`define TXERR_TIMEOUT_BIT 1
`define TX_DESC_END 32'hFFFF_FFFF
`define TX_DESC_ALIGN_W 3

// ==========================================================================
// Interrupt status bits
`define IRQ_CALL_DONE 0
`define IRQ_TX_ERROR 1
`define IRQ_BUF_AREA 2
`define IRQ_RX_READY 3
`define IRQ_W 4

`endif

/* rx_descriptor_pack.v */
// Packs a received buffer into its descriptor word and rebuilds the start
// address from a stored descriptor. Purely combinational.
`include "mac_dma_call_defs.vh"
`default_nettype none

module rx_descriptor_pack (
  // Incoming buffer
  input wire [11:0] word_count_i,
  input wire [31:0] buf_addr_i,
  // Stored descriptor and rebuilt address
  input wire [31:0] desc_i,
  output wire [31:0] desc_o,
  output wire [31:0] start_addr_o
);

  assign desc_o = {{`DESC_PAD_W{1'b0}},
                   word_count_i,
                   buf_addr_i[`ADDR_BUF_HI:`ADDR_BUF_LO]};

  // Bits 15:7 land on 26:18 and 6:0 on 17:11 in one slice
  assign start_addr_o = {`ADDR_PATTERN,
                         desc_i[`DESC_ADDR_HI:`DESC_ADDR_LO],
                         {`ADDR_ZERO_W{1'b0}}};

endmodule // rx_descriptor_pack

`default_nettype wire

/* tx_error_tracker.v */
// Sticky transmit MAC DMA error causes, read and cleared by the query call.
// Assumes error inputs are one-cycle pulses synchronous to clk_i.
`include "mac_dma_call_defs.vh"
`default_nettype none

module tx_error_tracker (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Error causes
  input wire unacquired_i,
  input wire bad_count_i,
  input wire desc_valid_i,
  input wire [31:0] desc_addr_i,
  input wire auto_release_fail_i,
  // Query
  input wire query_i,
  output wire [1:0] cause_o,
  output reg error_pulse_o
);

  reg violation;
  reg timeout;
  wire misaligned;
  wire set_violation;
  wire set_timeout;

  assign misaligned = desc_valid_i && (desc_addr_i[`TX_DESC_ALIGN_W-1:0] != 3'h0);
  assign set_violation = unacquired_i || bad_count_i || misaligned;
  assign set_timeout = auto_release_fail_i ||
                       (desc_valid_i && (desc_addr_i == `TX_DESC_END));
  assign cause_o = {timeout, violation};

  // Set beats the query's clear; the two bits never touch each other
  always @(posedge clk_i) begin
    if (rst_i) begin
      violation <= 1'b0;
      timeout <= 1'b0;
      error_pulse_o <= 1'b0;
    end else begin
      violation <= set_violation || (violation && !query_i);
      timeout <= set_timeout || (timeout && !query_i);
      error_pulse_o <= set_violation || set_timeout;
    end
  end

endmodule // tx_error_tracker

`default_nettype wire

/* mac_dma_call_ctrl_asserts.sv */
// Checker for the call front end, bound to the top module.
// Assumes one clock and a synchronous active-high reset.
`include "mac_dma_call_defs.vh"
`default_nettype none
module mac_dma_call_ctrl_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Calls
  input wire logic call_start_o,
  input wire logic [3:0] call_code_o,
  input wire logic [31:0] src_addr_o,
  input wire logic call_done_i,
  input wire logic call_fault_i,
  // Events
  input wire logic tx_unacquired_i,
  input wire logic tx_bad_count_i,
  input wire logic tx_desc_valid_i,
  input wire logic [31:0] tx_desc_addr_i,
  input wire logic tx_auto_release_fail_i,
  input wire logic bram_unacquired_i,
  input wire logic tx_dma_error_irq_o,
  input wire logic buffer_area_error_irq_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Bus and call sequencing
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  start_gap_a: assert property (call_start_o |=> !call_start_o [*3])
    else $error("call start repeated");
  start_args_a: assert property (
    call_start_o |-> src_addr_o != 32'h0 && src_addr_o[1:0] == 2'h0)
    else $error("bad call started");
  // ==========
  // Error routing; tracker and pulse stage each add a cycle on tx causes
  tx_cause_a: assert property (
    tx_unacquired_i || tx_bad_count_i || tx_auto_release_fail_i |-> ##2 tx_dma_error_irq_o)
    else $error("tx error pulse missing");
  misalign_a: assert property (
    tx_desc_valid_i && tx_desc_addr_i[2:0] != 3'h0 |-> ##2 tx_dma_error_irq_o)
    else $error("misaligned descriptor unflagged");
  buf_area_a: assert property (bram_unacquired_i |=> buffer_area_error_irq_o)
    else $error("buffer area pulse missing");
  mac_fault_a: assert property (
    call_done_i && call_fault_i && call_code_o == `CALL_TX_DMA |=> tx_dma_error_irq_o)
    else $error("tx call fault not raised");
  launch_fault_a: assert property (
    call_done_i && call_fault_i &&
    call_code_o inside {`CALL_RX_DMA, `CALL_BRAM_LAUNCH, `CALL_BRAM_LAUNCH_DESC}
    |=> buffer_area_error_irq_o)
    else $error("launch fault not raised");
  copy_quiet_a: assert property (
    call_done_i && call_fault_i && !bram_unacquired_i &&
    call_code_o inside {`CALL_DIRECT_COPY, `CALL_DIRECT_REPLACE}
    |=> !buffer_area_error_irq_o)
    else $error("copy fault raised irq");
  cover property (call_start_o);
  cover property (tx_dma_error_irq_o);
  cover property (irq_o);
endmodule // mac_dma_call_ctrl_chk
bind mac_dma_call_ctrl mac_dma_call_ctrl_chk chk (.*);
`default_nettype wire

/* dma_engine_model.sv */
// Behavioural DMA engine answering each started call after a delay.
// Assumes start is a pulse and the fault request holds for the call.
`default_nettype none
module dma_engine_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Call handshake
  input wire logic start_i,
  input wire logic fault_req_i,
  input wire logic [3:0] lat_i,
  output logic done_o,
  output logic fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [3:0] cnt;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy <= 1'b0;
    end else if (start_i) begin
      busy <= 1'b1;
      cnt <= lat_i;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      done_o <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
  // Off the done pulse the flag is junk, so show its inverse
  assign fault_o = done_o ? fault_req_i : ~fault_req_i;
endmodule // dma_engine_model
`default_nettype wire

/* mac_dma_call_ctrl_tb.sv */
// Self-checking bench for the call front end with a DMA engine model.
// Assumes the checker file binds itself to the design.
`include "mac_dma_call_defs.vh"
`default_nettype none
module mac_dma_call_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, rx_done_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF, call_code_o, lat = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, src_addr_o, dst_addr_o, rx_buf_addr_i = 0;
  logic [31:0] tx_desc_addr_i = 0;
  logic [11:0] rx_word_count_i = 0;
  logic wb_ack_o, call_start_o, call_done_i, call_fault_i, fault = 0, bram_unacquired_i = 0;
  logic tx_unacquired_i = 0, tx_bad_count_i = 0, tx_desc_valid_i = 0, tx_auto_release_fail_i = 0;
  logic tx_dma_error_irq_o, buffer_area_error_irq_o, irq_o;
  int n_errors = 0, comparisons = 0;
  logic [71:0] exp_q[$];
  logic [4:0] tbl[8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h05, 5'h11};
  mac_dma_call_ctrl dut (.*);
  dma_engine_model eng (.clk_i(clk_i), .rst_i(rst_i), .start_i(call_start_o),
    .fault_req_i(fault), .lat_i(lat), .done_o(call_done_i), .fault_o(call_fault_i));
  // ==========
  // Checking
  task automatic chk(input logic [7:0] id, input logic [63:0] got);
    logic [71:0] e;
    e = exp_q.pop_front();
    comparisons++;
    if (e !== {id, got}) begin
      n_errors++;
      $display("[FAIL] item %h expected %h seen %h", id, e[63:0], got);
    end
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_adr_i, {32'h0, wb_dat_o});
    if (call_start_o === 1'b1) chk({4'hF, call_code_o}, {src_addr_o, dst_addr_o});
  end
  task automatic end_of_test;
    // A result that never appeared is a mismatch too
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("[FAIL] pending results expected 0 seen %0d", exp_q.size());
    end
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // Bus and call tasks
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({a, 32'h0, e});
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] ra();
    return ($urandom | 32'h0000_0004) & 32'hFFFF_FFFC;
  endfunction
  // Waits on the call-done interrupt rather than polling busy
  task automatic call(input logic [3:0] c, input logic [31:0] a1, a2, res, input logic st);
    if (st) exp_q.push_back({4'hF, c, a1, a2});
    bus(1'b1, `OFS_FIRST_ARG, a1);
    bus(1'b1, `OFS_SECOND_ARG, a2);
    bus(1'b1, `OFS_CALL_CODE, {28'h0, c});
    while (irq_o !== 1'b1) begin
      @(posedge clk_i);
    end
    bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(`OFS_RESULT_WORD, res);
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #200_000;
    n_errors++;
    end_of_test();
  end
  // ==========
  // Scenarios
  initial begin
    logic [31:0] a;
    logic [11:0] w;
    logic [4:0] v;
    logic [31:0] r;
    void'($urandom(32'h614e_b754));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`OFS_RESULT_WORD, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0001);
    repeat (3) begin
      w = 12'($urandom);
      a = ra();
      rx_word_count_i <= w;
      rx_buf_addr_i <= a;
      rx_done_i <= 1'b1;
      @(posedge clk_i);
      rx_done_i <= 1'b0;
      @(posedge clk_i);
      rd(`OFS_RX_DESC, {4'h0, w, a[26:11]});
      rd(`OFS_RX_START_ADDR, {5'h01, a[26:11], 11'h0});
      call(`CALL_BUF_RELEASE, {5'h01, a[26:11], 11'h0}, ra(), `RESULT_OK, 1'b1);
    end
    bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_000F);
    for (int c = 1; c <= 6; c++) begin
      call(c[3:0], 32'h0, ra(), `RESULT_INVALID_CALL, 1'b0);
      call(c[3:0], ra() | 32'h0000_0002, ra(), `RESULT_INVALID_CALL, 1'b0);
      for (int f = 0; f < 2; f++) begin
        fault <= f[0];
        lat <= 4'($urandom);
        r = (f && c >= 5) ? `RESULT_EXCEPTION : `RESULT_OK;
        call(c[3:0], ra(), ra(), r, 1'b1);
        rd(`OFS_IRQ_STATUS, !f ? 32'h0 : c == 2 ? 32'h2 : c < 5 ? 32'h4 : 32'h0);
        bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_000F);
      end
    end
    call(4'hF, ra(), ra(), `RESULT_INVALID_CALL, 1'b0);
    fault <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = tbl[i];
      tx_unacquired_i <= v[0];
      bram_unacquired_i <= v[0];
      tx_bad_count_i <= v[1];
      tx_auto_release_fail_i <= v[4];
      tx_desc_valid_i <= 1'b1;
      tx_desc_addr_i <= v[3] ? `TX_DESC_END : (ra() & 32'hFFFF_FFF8) | {29'h0, v[2], 2'h0};
      @(posedge clk_i);
      tx_unacquired_i <= 1'b0;
      bram_unacquired_i <= 1'b0;
      tx_bad_count_i <= 1'b0;
      tx_auto_release_fail_i <= 1'b0;
      tx_desc_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(`OFS_IRQ_STATUS, {29'h0, v[0], |v, 1'b0});
      exp_q.push_back({8'hEE, 64'h0});
      chk(8'hEE, {63'h0, irq_o});
      call(`CALL_TX_ERR_QUERY, ra(), ra(), {30'h0, v[3] | v[4], |v[3:0]}, 1'b0);
      call(`CALL_TX_ERR_QUERY, ra(), ra(), `RESULT_OK, 1'b0);
      bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_000F);
    end
    end_of_test();
  end
endmodule // mac_dma_call_ctrl_tb
`default_nettype wire
